// File: verilog/port_pins.v
// Port pin logic: open-drain port, analog input port, pull-up ports,
// sync pins, strobes, straps and reset pin, behind a Wishbone slave.
// Assumes pins are synchronous to clk_i; pull-ups are resolved outside.
// Function
// - Open-drain port pins only pull low.
// - Latched one floats the open-drain pin.
// - Four input-only pins also feed converter.
// - Third port pulled high, readable when one.
// - Third alternate functions need latch one.
// - Third port alternate function bit mapping.
// - Multifunction port pulled high, readable when one.
// - Multifunction bits carry both modulator outputs.
// - Fourth bits two, three carry strobes.
// - Fourth address lines after reset, else port.
// - Vertical sync pin: sync, input, odd/even.
// - Horizontal sync pin input or sync output.
// - Strobes active on extended RAM moves.
// - Low reset pin resets the device.
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "port_pins_map.vh"
module port_pins #(
    parameter WIDTH = 8,
    parameter ANALOG_WIDTH = 4,
    parameter PWM8_CHANNELS = 6,
    parameter PWM14_CHANNELS = 2
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [4:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Open-drain port pins
    input wire [WIDTH-1:0] open_drain_port_i,
    output wire [WIDTH-1:0] open_drain_port_o,
    output wire [WIDTH-1:0] open_drain_port_oe_o,
    // Analog input port pins and converter feed
    input wire [ANALOG_WIDTH-1:0] analog_input_port_i,
    output reg [ANALOG_WIDTH-1:0] analog_channel_o,
    // Multifunction port pins and modulator outputs
    input wire [WIDTH-1:0] multifunction_port_i,
    output wire [WIDTH-1:0] multifunction_port_o,
    output wire [WIDTH-1:0] multifunction_port_oe_o,
    input wire [PWM8_CHANNELS-1:0] pwm8_i,
    input wire [PWM14_CHANNELS-1:0] pwm14_i,
    // Third port pins
    input wire [WIDTH-1:0] third_port_i,
    output wire [WIDTH-1:0] third_port_o,
    output wire [WIDTH-1:0] third_port_oe_o,
    // Third port alternate functions
    input wire odd_even_i,
    input wire txd_i,
    output reg extra_interrupt_zero_o,
    output reg interrupt_gate_zero_o,
    output reg interrupt_gate_one_o,
    output reg counter_input_zero_o,
    output reg counter_input_one_o,
    output reg extra_interrupt_one_o,
    // Fourth port pins
    input wire [WIDTH-1:0] fourth_port_i,
    output wire [WIDTH-1:0] fourth_port_o,
    output wire [WIDTH-1:0] fourth_port_oe_o,
    input wire [2:0] upper_address_line_i,
    // Extended data RAM access strobes
    input wire extended_data_ram_read_i,
    input wire extended_data_ram_write_i,
    output reg read_strobe_n_o,
    output reg write_strobe_n_o,
    // Sync pins
    input wire vertical_sync_pin_i,
    output reg vertical_sync_pin_o,
    output reg vertical_sync_pin_oe_o,
    input wire horizontal_sync_pin_i,
    output reg horizontal_sync_pin_o,
    output reg horizontal_sync_pin_oe_o,
    input wire vsync_gen_i,
    input wire hsync_gen_i,
    input wire composite_sync_out_i,
    output reg vsync_in_o,
    output reg hsync_in_o,
    // Reset pin and straps
    input wire reset_pin_n_i,
    input wire extended_memory_strap_n_i,
    input wire external_program_strap_n_i,
    output reg device_reset_o,
    output reg ext_memory_enable_o,
    output reg ext_program_o,
    output reg test_mode_o
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg [WIDTH-1:0] open_drain_latch;
    reg [WIDTH-1:0] multi_latch;
    reg [WIDTH-1:0] third_latch;
    reg [WIDTH-1:0] fourth_latch;
    reg [`CTL_WIDTH-1:0] pin_control;
    reg [31:0] next_dat;
    wire reset_any;
    wire req;
    wire [WIDTH-1:0] open_drain_level;
    wire [WIDTH-1:0] multi_level;
    wire [WIDTH-1:0] third_level;
    wire [WIDTH-1:0] fourth_level;
    wire [WIDTH-1:0] third_alt_in;
    wire [WIDTH-1:0] multi_alt_val;
    wire [WIDTH-1:0] third_alt_sel;
    wire [WIDTH-1:0] third_alt_val;
    wire [WIDTH-1:0] fourth_alt_sel;
    wire [WIDTH-1:0] fourth_alt_val;
    wire master;
    wire sync_out;

    // The reset pin and the system reset both clear the block.
    assign reset_any = rst_i | ~reset_pin_n_i;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign master = pin_control[`CTL_MASTER_MODE];
    assign sync_out = pin_control[`CTL_COMPOSITE_SYNC] ? composite_sync_out_i : hsync_gen_i;

    // ****************************************************************
    // Wishbone writes and latches
    // ****************************************************************
    always @(posedge clk_i) begin
        if (reset_any) begin
            open_drain_latch <= `LATCH_RESET;
            multi_latch <= `LATCH_RESET;
            third_latch <= `LATCH_RESET;
            fourth_latch <= `LATCH_RESET;
            pin_control <= `CONTROL_RESET;
        end else if (req && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                `ADDR_OPEN_DRAIN_LATCH: begin
                    open_drain_latch <= wb_dat_i[WIDTH-1:0];
                end
                `ADDR_MULTI_LATCH: begin
                    multi_latch <= wb_dat_i[WIDTH-1:0];
                end
                `ADDR_THIRD_LATCH: begin
                    third_latch <= wb_dat_i[WIDTH-1:0];
                end
                `ADDR_FOURTH_LATCH: begin
                    fourth_latch <= wb_dat_i[WIDTH-1:0];
                end
                `ADDR_PIN_CONTROL: begin
                    pin_control <= wb_dat_i[`CTL_WIDTH-1:0];
                end
                default: begin
                    pin_control <= pin_control;
                end
            endcase
        end
    end

    // ****************************************************************
    // Wishbone reads
    // ****************************************************************
    always @* begin
        next_dat = `WORD_ZERO;
        case (wb_adr_i)
            `ADDR_OPEN_DRAIN_LATCH: begin
                next_dat[WIDTH-1:0] = open_drain_latch;
            end
            `ADDR_MULTI_LATCH: begin
                next_dat[WIDTH-1:0] = multi_latch;
            end
            `ADDR_THIRD_LATCH: begin
                next_dat[WIDTH-1:0] = third_latch;
            end
            `ADDR_FOURTH_LATCH: begin
                next_dat[WIDTH-1:0] = fourth_latch;
            end
            `ADDR_PIN_CONTROL: begin
                next_dat[`CTL_WIDTH-1:0] = pin_control;
            end
            `ADDR_PIN_LEVELS: begin
                next_dat = {fourth_level, third_level, multi_level, open_drain_level};
            end
            `ADDR_INPUT_STATUS: begin
                next_dat[`STAT_ANALOG_MSB:`STAT_ANALOG_LSB] = analog_channel_o;
                next_dat[`STAT_EXT_MEM] = ext_memory_enable_o;
                next_dat[`STAT_EXT_PROG] = ext_program_o;
                next_dat[`STAT_TEST_MODE] = test_mode_o;
                next_dat[`STAT_VSYNC_LEVEL] = vsync_in_o;
            end
            default: begin
                next_dat = `WORD_ZERO;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (reset_any) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `WORD_ZERO;
        end else begin
            // Every address is answered after one cycle; unmapped ones read zero.
            wb_ack_o <= req;
            wb_dat_o <= req ? next_dat : `WORD_ZERO;
        end
    end

    // ****************************************************************
    // Alternate output routing
    // ****************************************************************
    // Both modulators share the multifunction port in fixed positions.
    assign multi_alt_val = {pwm14_i, pwm8_i};

    // Odd/even goes to bit 0 unless moved to the vertical sync pin.
    assign third_alt_sel = {2'b00,
                            master & pin_control[`CTL_THIRD5_SYNC_OUT],
                            3'b000,
                            1'b1,
                            ~pin_control[`CTL_ODD_EVEN_ON_VSYNC]};
    assign third_alt_val = {2'b11, sync_out, 3'b111, txd_i, odd_even_i};

    // Address mode holds after reset; port mode is chosen by software.
    assign fourth_alt_sel = (pin_control[`CTL_FOURTH_PORT_MODE] ? 8'h00 : `FOURTH_ADDR_MASK) |
        (pin_control[`CTL_STROBES_ON_FOURTH] ? `FOURTH_STROBE_MASK : 8'h00);
    assign fourth_alt_val = {3'b111, upper_address_line_i[2], ~extended_data_ram_write_i, ~extended_data_ram_read_i,
                             upper_address_line_i[1:0]};

    // ****************************************************************
    // Port instances
    // ****************************************************************
    // A one in the latch releases the pin; a zero pulls it low.
    quasi_port #(.WIDTH(WIDTH)) open_drain_port_u (
        .clk_i(clk_i),
        .rst_i(reset_any),
        .latch_i(open_drain_latch),
        .alt_sel_i({WIDTH{1'b0}}),
        .alt_val_i({WIDTH{1'b1}}),
        .pin_i(open_drain_port_i),
        .pin_o(open_drain_port_o),
        .pin_oe_o(open_drain_port_oe_o),
        .level_o(open_drain_level),
        .alt_in_o()
    );

    quasi_port #(.WIDTH(WIDTH)) multifunction_port_u (
        .clk_i(clk_i),
        .rst_i(reset_any),
        .latch_i(multi_latch),
        .alt_sel_i({WIDTH{1'b1}}),
        .alt_val_i(multi_alt_val),
        .pin_i(multifunction_port_i),
        .pin_o(multifunction_port_o),
        .pin_oe_o(multifunction_port_oe_o),
        .level_o(multi_level),
        .alt_in_o()
    );

    quasi_port #(.WIDTH(WIDTH)) third_port_u (
        .clk_i(clk_i),
        .rst_i(reset_any),
        .latch_i(third_latch),
        .alt_sel_i(third_alt_sel),
        .alt_val_i(third_alt_val),
        .pin_i(third_port_i),
        .pin_o(third_port_o),
        .pin_oe_o(third_port_oe_o),
        .level_o(third_level),
        .alt_in_o(third_alt_in)
    );

    quasi_port #(.WIDTH(WIDTH)) fourth_port_u (
        .clk_i(clk_i),
        .rst_i(reset_any),
        .latch_i(fourth_latch),
        .alt_sel_i(fourth_alt_sel),
        .alt_val_i(fourth_alt_val),
        .pin_i(fourth_port_i),
        .pin_o(fourth_port_o),
        .pin_oe_o(fourth_port_oe_o),
        .level_o(fourth_level),
        .alt_in_o()
    );

    // ****************************************************************
    // Alternate inputs, strobes and sync pins
    // ****************************************************************
    always @(posedge clk_i) begin
        if (reset_any) begin
            analog_channel_o <= {ANALOG_WIDTH{1'b0}};
            extra_interrupt_zero_o <= 1'b1;
            interrupt_gate_zero_o <= 1'b1;
            interrupt_gate_one_o <= 1'b1;
            counter_input_zero_o <= 1'b1;
            counter_input_one_o <= 1'b1;
            extra_interrupt_one_o <= 1'b1;
            read_strobe_n_o <= 1'b1;
            write_strobe_n_o <= 1'b1;
            vertical_sync_pin_o <= 1'b0;
            vertical_sync_pin_oe_o <= 1'b0;
            horizontal_sync_pin_o <= 1'b0;
            horizontal_sync_pin_oe_o <= 1'b0;
            vsync_in_o <= 1'b0;
            hsync_in_o <= 1'b0;
        end else begin
            analog_channel_o <= analog_input_port_i;
            extra_interrupt_zero_o <= third_alt_in[`THIRD_TXD];
            interrupt_gate_zero_o <= third_alt_in[2];
            interrupt_gate_one_o <= third_alt_in[3];
            counter_input_zero_o <= third_alt_in[4];
            counter_input_one_o <= third_alt_in[`THIRD_SYNC];
            extra_interrupt_one_o <= third_alt_in[7];
            read_strobe_n_o <= ~extended_data_ram_read_i;
            write_strobe_n_o <= ~extended_data_ram_write_i;
            if (pin_control[`CTL_ODD_EVEN_ON_VSYNC]) begin
                vertical_sync_pin_o <= odd_even_i;
                vertical_sync_pin_oe_o <= 1'b1;
            end else begin
                vertical_sync_pin_o <= vsync_gen_i;
                vertical_sync_pin_oe_o <= master & pin_control[`CTL_VSYNC_OUT];
            end
            vsync_in_o <= vertical_sync_pin_i;
            horizontal_sync_pin_o <= sync_out;
            horizontal_sync_pin_oe_o <= master;
            hsync_in_o <= master ? 1'b0 : horizontal_sync_pin_i;
        end
    end

    // ****************************************************************
    // Reset output and straps
    // ****************************************************************
    always @(posedge clk_i) begin
        device_reset_o <= reset_any;
        if (reset_any) begin
            // Straps are sampled while reset is held and kept afterwards.
            ext_memory_enable_o <= ~extended_memory_strap_n_i;
            ext_program_o <= ~external_program_strap_n_i;
            test_mode_o <= ~third_port_i[`THIRD_TEST];
        end
    end

endmodule // port_pins

// File: verilog/port_pins_map.vh
// Offsets, field positions and reset values of the port pin block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
`ifndef PORT_PINS_MAP_VH
`define PORT_PINS_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_OPEN_DRAIN_LATCH 5'h00
`define ADDR_MULTI_LATCH 5'h04
`define ADDR_THIRD_LATCH 5'h08
`define ADDR_FOURTH_LATCH 5'h0C
`define ADDR_PIN_CONTROL 5'h10
`define ADDR_PIN_LEVELS 5'h14
`define ADDR_INPUT_STATUS 5'h18

// ****************************************************************
// Control fields
// ****************************************************************
`define CTL_MASTER_MODE 0
`define CTL_VSYNC_OUT 1
`define CTL_ODD_EVEN_ON_VSYNC 2
`define CTL_COMPOSITE_SYNC 3
`define CTL_STROBES_ON_FOURTH 4
`define CTL_FOURTH_PORT_MODE 5
`define CTL_THIRD5_SYNC_OUT 6
`define CTL_WIDTH 7

// ****************************************************************
// Status fields
// ****************************************************************
`define STAT_ANALOG_LSB 0
`define STAT_ANALOG_MSB 3
`define STAT_EXT_MEM 4
`define STAT_EXT_PROG 5
`define STAT_TEST_MODE 6
`define STAT_VSYNC_LEVEL 7

// ****************************************************************
// Fourth and third port bit positions
// ****************************************************************
`define FOURTH_ADDR0 0
`define FOURTH_ADDR1 1
`define FOURTH_READ 2
`define FOURTH_WRITE 3
`define FOURTH_ADDR2 4
`define FOURTH_VSYNC 7
`define THIRD_ODD_EVEN 0
`define THIRD_TXD 1
`define THIRD_SYNC 5
`define THIRD_TEST 6

// ****************************************************************
// Reset values and fourth port masks
// ****************************************************************
`define LATCH_RESET 8'hFF
`define CONTROL_RESET 7'h00
`define FOURTH_ADDR_MASK 8'h13
`define FOURTH_STROBE_MASK 8'h0C
`define WORD_ZERO 32'h0000_0000

`endif

// File: verilog/quasi_port.v
// One port of pull-down-only pins with optional alternate outputs.
// Assumes pin inputs are synchronous to clk_i and the pull-up sits outside.
`timescale 1ns/1ps
module quasi_port #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Latch and alternate outputs
    input wire [WIDTH-1:0] latch_i,
    input wire [WIDTH-1:0] alt_sel_i,
    input wire [WIDTH-1:0] alt_val_i,
    // Pins
    input wire [WIDTH-1:0] pin_i,
    output reg [WIDTH-1:0] pin_o,
    output reg [WIDTH-1:0] pin_oe_o,
    // Reads and alternate inputs
    output reg [WIDTH-1:0] level_o,
    output reg [WIDTH-1:0] alt_in_o
);

    wire [WIDTH-1:0] drive;

    // A pin with a cleared latch is held low whatever its alternate value.
    assign drive = latch_i & ((alt_sel_i & alt_val_i) | ~alt_sel_i);

    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= {WIDTH{1'b0}};
            pin_oe_o <= {WIDTH{1'b0}};
            level_o <= {WIDTH{1'b1}};
            alt_in_o <= {WIDTH{1'b1}};
        end else begin
            pin_o <= {WIDTH{1'b0}};
            pin_oe_o <= ~drive;
            level_o <= pin_i;
            // Alternate inputs only see the pin while its latch holds one.
            alt_in_o <= pin_i | ~latch_i;
        end
    end

endmodule // quasi_port

// File: testbench/port_pins_chk.sv
// Concurrent checks on the ports of the port pin block.
// Assumes one clock, synchronous active-high rst_i and an active-low reset pin.
`timescale 1ns/1ps
module port_pins_chk #(
    parameter WIDTH = 8,
    parameter ANALOG_WIDTH = 4
) (
    // Clock and resets
    input wire clk_i,
    input wire rst_i,
    input wire reset_pin_n_i,
    // Register bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    // Pins and converter feed
    input wire [WIDTH-1:0] open_drain_port_o,
    input wire [WIDTH-1:0] open_drain_port_oe_o,
    input wire [WIDTH-1:0] third_port_i,
    input wire counter_input_zero_o,
    input wire [ANALOG_WIDTH-1:0] analog_input_port_i,
    input wire [ANALOG_WIDTH-1:0] analog_channel_o,
    // Strobes and reset output
    input wire extended_data_ram_read_i,
    input wire extended_data_ram_write_i,
    input wire read_strobe_n_o,
    input wire write_strobe_n_o,
    input wire device_reset_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i || !reset_pin_n_i);
    sequence s_request;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_release;
        rst_i ##1 !rst_i;
    endsequence
    a_ack_follows: assert property (s_request |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
    a_od_no_high: assert property (open_drain_port_o == '0)
        else $error("open-drain port drives a high level");
    a_od_reset_float: assert property (disable iff (!reset_pin_n_i)
        s_release |=> open_drain_port_oe_o == '0)
        else $error("open-drain pin pulled low after reset");
    a_read_strobe: assert property (extended_data_ram_read_i |=> !read_strobe_n_o)
        else $error("read strobe missing");
    a_write_strobe: assert property (1'b1 |=> write_strobe_n_o == !$past(extended_data_ram_write_i))
        else $error("write strobe does not follow the access");
    a_alt_in_high: assert property (third_port_i[4] |-> ##2 counter_input_zero_o)
        else $error("counter input low while its pin is high");
    a_analog_copy: assert property (!device_reset_o |=>
        analog_channel_o == $past(analog_input_port_i))
        else $error("converter feed differs from the pins");
    a_reset_pin: assert property (disable iff (rst_i) !reset_pin_n_i |=> device_reset_o)
        else $error("reset pin low without device reset");
endmodule // port_pins_chk

bind port_pins port_pins_chk #(.WIDTH(WIDTH), .ANALOG_WIDTH(ANALOG_WIDTH)) chk_u (.*);

// File: testbench/board_model.sv
// Board model: pull-ups, external pin drive, sync sources and strap pins.
// Assumes the design drives its port pins only low, through the enables.
`timescale 1ns/1ps
module board_model (
    // Design enables and sync drives
    input wire [7:0] open_drain_oe_i,
    input wire [7:0] multi_oe_i,
    input wire [7:0] third_oe_i,
    input wire [7:0] fourth_oe_i,
    input wire vsync_oe_i,
    input wire vsync_val_i,
    input wire hsync_oe_i,
    input wire hsync_val_i,
    // Board drive, bytes {fourth, third, multi, open-drain}
    input wire [31:0] pull_low_i,
    input wire vsync_ext_i,
    input wire hsync_ext_i,
    // Resolved pins and straps
    output wire [7:0] open_drain_pin_o,
    output wire [7:0] multi_pin_o,
    output wire [7:0] third_pin_o,
    output wire [7:0] fourth_pin_o,
    output wire vsync_pin_o,
    output wire hsync_pin_o,
    output wire ext_mem_strap_n_o,
    output wire ext_prog_strap_n_o
);
    // A released pin is pulled high unless the board pulls it low.
    assign open_drain_pin_o = ~(open_drain_oe_i | pull_low_i[7:0]);
    assign multi_pin_o = ~(multi_oe_i | pull_low_i[15:8]);
    // Bit 6 stays high in reset unless a test pulls it low on purpose.
    assign third_pin_o = ~(third_oe_i | pull_low_i[23:16]);
    assign fourth_pin_o = ~(fourth_oe_i | pull_low_i[31:24]);
    assign vsync_pin_o = vsync_oe_i ? vsync_val_i : vsync_ext_i;
    assign hsync_pin_o = hsync_oe_i ? hsync_val_i : hsync_ext_i;
    assign ext_mem_strap_n_o = 1'b0;
    assign ext_prog_strap_n_o = 1'b0;
endmodule // board_model

// File: testbench/testbench.sv
// Self-checking bench for the port pin block with a board model.
// Assumes the register map header is on the include path.
`timescale 1ns/1ps
`include "port_pins_map.vh"
`define CHECK(what, exp, got) \
    num_checks++; \
    if ((got) !== (exp)) begin \
        $display("wrong value %s expected %h seen %h", what, exp, got); \
        miscompares++; \
    end
module testbench;
    logic clk_i = 1'b0, rst_i = 1'b1, reset_pin_n_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [4:0] wb_adr_i = 5'h00;
    logic [3:0] wb_sel_i = 4'h0, analog_input_port_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, pull_low = 32'h0000_0000, rdat;
    logic [5:0] pwm8_i = 6'h3F;
    logic [1:0] pwm14_i = 2'h3;
    logic [2:0] upper_address_line_i = 3'h0;
    logic odd_even_i = 1'b1, txd_i = 1'b1, vs_ext = 1'b1, hs_ext = 1'b1;
    logic extended_data_ram_read_i = 1'b0, extended_data_ram_write_i = 1'b0, vsync_gen_i = 1'b0, hsync_gen_i = 1'b0;
    logic composite_sync_out_i = 1'b0;
    int miscompares = 0, num_checks = 0, cycles = 0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, read_strobe_n_o, write_strobe_n_o, device_reset_o, test_mode_o;
    wire ext_memory_enable_o, ext_program_o, vsync_in_o, hsync_in_o;
    wire vertical_sync_pin_i, vertical_sync_pin_o, vertical_sync_pin_oe_o;
    wire horizontal_sync_pin_i, horizontal_sync_pin_o, horizontal_sync_pin_oe_o;
    wire extended_memory_strap_n_i, external_program_strap_n_i;
    wire [7:0] open_drain_port_i, open_drain_port_o, open_drain_port_oe_o;
    wire [7:0] multifunction_port_i, multifunction_port_oe_o, third_port_i, third_port_oe_o;
    wire [7:0] fourth_port_i, fourth_port_oe_o, multifunction_port_o, third_port_o, fourth_port_o;
    wire [3:0] analog_channel_o;
    wire extra_interrupt_zero_o, interrupt_gate_zero_o, interrupt_gate_one_o;
    wire counter_input_zero_o, counter_input_one_o, extra_interrupt_one_o;
    wire [5:0] alt_in = {extra_interrupt_one_o, counter_input_one_o, counter_input_zero_o,
        interrupt_gate_one_o, interrupt_gate_zero_o, extra_interrupt_zero_o};

    always #5 clk_i = ~clk_i;
    port_pins dut_u (.*);
    board_model board_u (
        .open_drain_oe_i(open_drain_port_oe_o), .multi_oe_i(multifunction_port_oe_o),
        .third_oe_i(third_port_oe_o), .fourth_oe_i(fourth_port_oe_o),
        .vsync_oe_i(vertical_sync_pin_oe_o), .vsync_val_i(vertical_sync_pin_o),
        .hsync_oe_i(horizontal_sync_pin_oe_o), .hsync_val_i(horizontal_sync_pin_o),
        .pull_low_i(pull_low), .vsync_ext_i(vs_ext), .hsync_ext_i(hs_ext),
        .open_drain_pin_o(open_drain_port_i), .multi_pin_o(multifunction_port_i),
        .third_pin_o(third_port_i), .fourth_pin_o(fourth_port_i),
        .vsync_pin_o(vertical_sync_pin_i), .hsync_pin_o(horizontal_sync_pin_i),
        .ext_mem_strap_n_o(extended_memory_strap_n_i),
        .ext_prog_strap_n_o(external_program_strap_n_i)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        `CHECK("bus ack", 1'b1, wb_ack_o)
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_sel_i <= 4'h0;
        @(posedge clk_i);
    endtask
    task t_reset_and_open_drain;
        for (int a = 0; a < 4; a++) begin
            wb(1'b0, 5'(a * 4), 32'h0000_0000);
            `CHECK("latch", 32'h0000_00FF, rdat)
        end
        wb(1'b1, `ADDR_OPEN_DRAIN_LATCH, 32'h0000_00A5);
        tick(2);
        `CHECK("od oe", 8'h5A, open_drain_port_oe_o)
        wb(1'b0, `ADDR_PIN_LEVELS, 32'h0000_0000);
        `CHECK("od level", 8'hA5, rdat[7:0])
        wb(1'b1, 5'h1C, 32'hFFFF_FFFF);
        wb(1'b0, 5'h1C, 32'h0000_0000);
        `CHECK("unmapped", 32'h0000_0000, rdat)
        $display("test open drain done");
    endtask
    task t_third;
        pull_low <= 32'h00B4_0000;
        tick(3);
        `CHECK("alt in", 6'b000101, alt_in)
        wb(1'b1, `ADDR_THIRD_LATCH, 32'h0000_004B);
        tick(3);
        `CHECK("alt off", 6'b111111, alt_in)
        `CHECK("third oe", 8'hB4, third_port_oe_o)
        wb(1'b1, `ADDR_THIRD_LATCH, 32'h0000_00FF);
        pull_low <= 32'h0000_0000;
        odd_even_i <= 1'b0;
        tick(3);
        `CHECK("odd even", 8'h01, third_port_oe_o)
        `CHECK("hi", 1'b0, |{multifunction_port_o, third_port_o, fourth_port_o})
        $display("test third port done");
    endtask
    task t_multi_analog;
        pwm8_i <= 6'h2A;
        pwm14_i <= 2'b01;
        analog_input_port_i <= 4'h9;
        tick(3);
        `CHECK("pwm oe", 8'h95, multifunction_port_oe_o)
        `CHECK("analog", 4'h9, analog_channel_o)
        wb(1'b0, `ADDR_INPUT_STATUS, 32'h0000_0000);
        `CHECK("analog st", 4'h9, rdat[3:0])
        wb(1'b1, `ADDR_MULTI_LATCH, 32'h0000_000F);
        tick(1);
        `CHECK("mf oe", 8'hF5, multifunction_port_oe_o)
        wb(1'b0, `ADDR_PIN_LEVELS, 32'h0000_0000);
        `CHECK("mf level", 8'h0A, rdat[15:8])
        $display("test multifunction done");
    endtask
    task t_fourth;
        upper_address_line_i <= 3'b101;
        tick(3);
        `CHECK("addr oe", 8'h02, fourth_port_oe_o)
        wb(1'b1, `ADDR_PIN_CONTROL, 32'h0000_0030);
        extended_data_ram_read_i <= 1'b1;
        tick(3);
        `CHECK("rd oe", 9'h004, {read_strobe_n_o, fourth_port_oe_o})
        extended_data_ram_read_i <= 1'b0;
        extended_data_ram_write_i <= 1'b1;
        tick(3);
        `CHECK("wr oe", 9'h008, {write_strobe_n_o, fourth_port_oe_o})
        extended_data_ram_write_i <= 1'b0;
        $display("test fourth port done");
    endtask
    task t_sync;
        hsync_gen_i <= 1'b1;
        vsync_gen_i <= 1'b1;
        wb(1'b1, `ADDR_PIN_CONTROL, 32'h0000_0003);
        tick(2);
        `CHECK("master", 4'hF, {vertical_sync_pin_oe_o, vertical_sync_pin_o,
            horizontal_sync_pin_oe_o, horizontal_sync_pin_o})
        wb(1'b1, `ADDR_PIN_CONTROL, 32'h0000_000B);
        tick(2);
        `CHECK("csync", 2'b10, {horizontal_sync_pin_oe_o, horizontal_sync_pin_o})
        wb(1'b1, `ADDR_PIN_CONTROL, 32'h0000_0004);
        tick(2);
        `CHECK("vs odd", 2'b10, {vertical_sync_pin_oe_o, vertical_sync_pin_o})
        wb(1'b1, `ADDR_PIN_CONTROL, 32'h0000_0000);
        vs_ext <= 1'b0;
        tick(3);
        `CHECK("slave", 3'b010, {horizontal_sync_pin_oe_o, hsync_in_o, vsync_in_o})
        wb(1'b0, `ADDR_INPUT_STATUS, 32'h0000_0000);
        `CHECK("vs st", 1'b0, rdat[7])
        $display("test sync done");
    endtask
    task t_reset_pin;
        pull_low <= 32'h0040_0000;
        reset_pin_n_i <= 1'b0;
        tick(3);
        `CHECK("dev rst", 1'b1, device_reset_o)
        reset_pin_n_i <= 1'b1;
        tick(2);
        pull_low <= 32'h0000_0000;
        wb(1'b0, `ADDR_INPUT_STATUS, 32'h0000_0000);
        `CHECK("straps", 3'b111, rdat[6:4])
        `CHECK("outs", 3'b111, {test_mode_o, ext_memory_enable_o, ext_program_o})
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        tick(2);
        `CHECK("test off", 1'b0, test_mode_o)
        $display("test reset pin done");
    endtask
    task results;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        tick(6);
        rst_i <= 1'b0;
        tick(1);
        t_reset_and_open_drain();
        t_third();
        t_multi_analog();
        t_fourth();
        t_sync();
        t_reset_pin();
        results();
    end
endmodule // testbench
